// ==== rtl/tsd_matrix_xlat.sv ====
`timescale 1ns/1ps
module tsd_matrix_xlat (
    // Clock and control
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic clr_in,
    // Group gating
    input wire logic grp_en_in,
    input wire logic res_strobe_in,
    input wire logic [5:0] leads_in,
    // Matrix selects
    output tsd_pkg::tsd_sel_s sel_out
);
    import tsd_pkg::*;

    function automatic logic [SEL_W-1:0] dec2(input logic hi, input logic lo, input logic en);
        dec2 = en ? (SEL_W'(1) << {hi, lo}) : '0;
    endfunction : dec2

    // Selects only reach a group whose number matched
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sel_out <= '0;
        end else if (ce_in) begin
            if (clr_in) begin
                sel_out <= '0;
            end else begin
                sel_out.clk_sel <= dec2(leads_in[LEAD_CLK_HI], leads_in[LEAD_CLK_LO],
                                        grp_en_in && res_strobe_in);
                sel_out.vert_sel <= dec2(leads_in[LEAD_VERT_HI], leads_in[LEAD_VERT_LO], grp_en_in);
                sel_out.horiz_sel <= dec2(leads_in[LEAD_HOR_HI], leads_in[LEAD_HOR_LO], grp_en_in);
            end
        end
    end
endmodule : tsd_matrix_xlat

// ==== rtl/tsd_onehot_dec.sv ====
`timescale 1ns/1ps
module tsd_onehot_dec #(
    parameter int W_IN = 4,
    parameter int N_OUT = 16
) (
    // Code in
    input wire logic [W_IN-1:0] code_in,
    input wire logic en_in,
    // One-hot out
    output logic [N_OUT-1:0] onehot_out
);
    import tsd_pkg::*;

    always_comb begin
        onehot_out = '0;
        for (int i = 0; i < N_OUT; i++) begin
            if (en_in && (code_in == W_IN'(i))) begin
                onehot_out[i] = 1'b1;
            end
        end
    end
endmodule : tsd_onehot_dec

// ==== rtl/tsd_pkg.sv ====
// Behaviour
// - Capture the 32 sense outputs of each read into a holding register.
// - Support normal and shifted message write-back of the holding register.
// - Each digit driver fires only with write active and its held bit set.
// - Gate, read, strobe and write intervals come from four phase pulses.
// - Calling address is word bits 8, 10 and 32 down to 25.
// - Called address is word bits 7, 9 and 24 down to 17.
// - Address splits into 4-bit group and 6-bit line; group decodes one of 16.
// - Provide one-hot selects for 6 digit trunks and 12 attendant circuits.
// - Flag called address all zero during talking slots.
// - Flag calling address all zero.
// - Bits 19 and 27 pick group bus; four intergroup drive pulses result.
// - Called party on bus 0 strobes its switch with the called bus-0 drive.
// - A selected digit trunk blocks both group-0 intergroup switches.
// - Either tone inhibit blocks the group-3 bus-1 intergroup switch.
// - Serve up to 15 groups of up to 64 circuits each.
// - Merge each party address with the controller select pulse into six leads.
// - Calling leads drive the forward matrix, called leads the reverse one.
// - Two matrices select two circuits of one group at once, any circuit.
// - A circuit is selected only with clock, vertical and horizontal selects.
// - Each controller path can activate any circuit of groups 0 to 14; group 15 trunks have no matrix.
// - Clock select decodes lead bits 6 and 3, gated by resonant strobe.
// - Vertical from lead bits 5 and 4, horizontal from 2 and 1, unstrobed.
package tsd_pkg;
    localparam int WORD_W = 32;
    localparam int GRP_W = 4;
    localparam int LINE_W = 6;
    localparam int GRP_CNT = 16;
    localparam int NUM_GROUPS = 15;
    localparam int DT_CNT = 6;
    localparam int ATT_CNT = 12;
    localparam int SEL_W = 4;
    // Word bit n sits at index n-1
    localparam int CALLING_HI_A = 7;
    localparam int CALLING_HI_B = 9;
    localparam int CALLING_LO_LSB = 24;
    localparam int CALLED_HI_A = 6;
    localparam int CALLED_HI_B = 8;
    localparam int CALLED_LO_LSB = 16;
    localparam int CALLED_BUS_BIT = 18;
    localparam int CALLING_BUS_BIT = 26;
    localparam int LEAD_CLK_HI = 5;
    localparam int LEAD_CLK_LO = 2;
    localparam int LEAD_VERT_HI = 4;
    localparam int LEAD_VERT_LO = 3;
    localparam int LEAD_HOR_HI = 1;
    localparam int LEAD_HOR_LO = 0;
    localparam int PHASE_PULSE_NS = 145;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PHASE_PULSE_CYC = (PHASE_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (PHASE_PULSE_NS / CLK_PERIOD_NS);
    localparam logic [3:0] SPECIAL_GRP = 4'hF;
    localparam logic [3:0] INHIBIT_GRP = 4'h0;
    localparam logic [3:0] TONE_GRP = 4'h3;
    localparam logic [5:0] DT_LIMIT = 6'h06;
    localparam logic [5:0] ATT_LIMIT = 6'h0C;
    localparam logic [5:0] ATT_BASE = 6'h10;

    typedef struct packed {
        logic [GRP_W-1:0] grp;
        logic [LINE_W-1:0] line;
    } tsd_party_s;

    typedef struct packed {
        logic [SEL_W-1:0] clk_sel;
        logic [SEL_W-1:0] vert_sel;
        logic [SEL_W-1:0] horiz_sel;
    } tsd_sel_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_STROBE = 2'b11,
        ST_HOLD = 2'b10
    } tsd_phase_e;

    function automatic tsd_party_s party_of(input logic [WORD_W-1:0] w, input int hi_a, input int hi_b,
                                            input int lo_lsb);
        party_of = {w[hi_a], w[hi_b], w[lo_lsb +: 8]};
    endfunction : party_of

    function automatic logic party_zero(input tsd_party_s p);
        party_zero = (p == '0);
    endfunction : party_zero
endpackage : tsd_pkg

// ==== rtl/tsd_word_decode.sv ====
`timescale 1ns/1ps
module tsd_word_decode #(
    parameter int NUM_GRP = tsd_pkg::NUM_GROUPS
) (
    // Clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // System clock phase pulses
    input wire logic phase_pulse_one_in,
    input wire logic phase_pulse_two_in,
    input wire logic phase_pulse_four_in,
    input wire logic phase_pulse_seven_in,
    // Slot and mode controls
    input wire logic talk_slot_in,
    input wire logic normal_msg_writeback_in,
    input wire logic shifted_msg_writeback_in,
    input wire logic msg_shift_bit_in,
    input wire logic time_division_controller_sel_in,
    // Pin inputs
    input wire logic [tsd_pkg::WORD_W-1:0] sense_bit_outputs_in,
    input wire logic tone_inhibit_a_in,
    input wire logic tone_inhibit_b_in,
    input wire logic resonant_strobe_in,
    // Store timing and write-back
    output logic gate_out,
    output logic read_out,
    output logic strobe_out,
    output logic write_out,
    output logic [tsd_pkg::WORD_W-1:0] digit_drive_out,
    output logic [tsd_pkg::WORD_W-1:0] held_word_out,
    // Pretranslator
    output logic [tsd_pkg::GRP_CNT-1:0] calling_grp_out,
    output logic [tsd_pkg::GRP_CNT-1:0] called_grp_out,
    output logic [tsd_pkg::DT_CNT-1:0] digit_trunk_sel_out,
    output logic [tsd_pkg::ATT_CNT-1:0] attendant_sel_out,
    output logic called_addr_zero_out,
    output logic calling_addr_zero_out,
    output logic calling_zero_alt_out,
    // Intergroup switch logic
    output logic called_bus_bit_low_out,
    output logic called_bus0_drive_out,
    output logic called_bus1_drive_out,
    output logic calling_bus0_drive_out,
    output logic calling_bus1_drive_out,
    output logic digit_trunk_grp0_inhibit_out,
    output logic [tsd_pkg::GRP_CNT-1:0] igs_bus0_out,
    output logic [tsd_pkg::GRP_CNT-1:0] igs_bus1_out,
    // Group select leads and matrices
    output logic [5:0] calling_select_leads_out,
    output logic [5:0] called_select_leads_out,
    output tsd_pkg::tsd_sel_s [NUM_GRP-1:0] fwd_matrix_sel_out,
    output tsd_pkg::tsd_sel_s [NUM_GRP-1:0] rev_matrix_sel_out
);
    import tsd_pkg::*;

    tsd_phase_e phase_reg;
    logic [WORD_W-1:0] sense_meta_reg;
    logic [WORD_W-1:0] sense_sync_reg;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [WORD_W-1:0] hold_reg;
    logic dec_valid_reg;
    logic tdc_sel_reg;
    logic slot_clr;
    logic capture;
    tsd_party_s calling_p;
    tsd_party_s called_p;
    logic [GRP_CNT-1:0] calling_oh;
    logic [GRP_CNT-1:0] called_oh;
    logic [DT_CNT-1:0] dt_oh;
    logic [ATT_CNT-1:0] att_oh;
    logic tone_inh;
    logic res_strobe;
    logic called_zero;
    logic calling_zero;
    logic dt_any;
    logic cd0;
    logic cd1;
    logic cg0;
    logic cg1;

    // Sense and pin levels are analogue-side, so synchronise first
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sense_meta_reg <= '0;
            sense_sync_reg <= '0;
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else if (ce_in) begin
            sense_meta_reg <= sense_bit_outputs_in;
            sense_sync_reg <= sense_meta_reg;
            pin_meta_reg <= {resonant_strobe_in, tone_inhibit_b_in, tone_inhibit_a_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign tone_inh = pin_sync_reg[0] | pin_sync_reg[1];
    assign res_strobe = pin_sync_reg[2];
    assign capture = (phase_reg == ST_STROBE) && phase_pulse_four_in;
    assign slot_clr = (phase_reg == ST_HOLD) && phase_pulse_one_in;

    // Store cycle sequencing
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            phase_reg <= ST_IDLE;
        end else if (ce_in) begin
            unique case (phase_reg)
                ST_IDLE: if (phase_pulse_one_in) phase_reg <= ST_READ;
                ST_READ: if (phase_pulse_two_in) phase_reg <= ST_STROBE;
                ST_STROBE: if (phase_pulse_four_in) phase_reg <= ST_HOLD;
                ST_HOLD: if (phase_pulse_one_in) phase_reg <= ST_READ;
            endcase
        end
    end

    // Interval flip-flops set and cleared by phase pulses
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            gate_out <= 1'b0;
            read_out <= 1'b0;
            strobe_out <= 1'b0;
            write_out <= 1'b0;
        end else if (ce_in) begin
            if (phase_pulse_one_in) begin
                gate_out <= 1'b1;
            end else if (phase_pulse_seven_in) begin
                gate_out <= 1'b0;
            end
            if (phase_pulse_one_in) begin
                read_out <= 1'b1;
            end else if (phase_pulse_two_in) begin
                read_out <= 1'b0;
            end
            if (phase_pulse_two_in && phase_reg == ST_READ) begin
                strobe_out <= 1'b1;
            end else if (phase_pulse_four_in) begin
                strobe_out <= 1'b0;
            end
            if (capture) begin
                write_out <= 1'b1;
            end else if (phase_pulse_seven_in) begin
                write_out <= 1'b0;
            end
        end
    end

    // Shifted write-back inserts one message bit at the low end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            hold_reg <= '0;
        end else if (ce_in && capture) begin
            if (shifted_msg_writeback_in) begin
                hold_reg <= {sense_sync_reg[WORD_W-2:0], msg_shift_bit_in};
            end else begin
                hold_reg <= sense_sync_reg;
            end
        end
    end

    // Destructive read: rewrite whatever is held
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            digit_drive_out <= '0;
        end else if (ce_in) begin
            digit_drive_out <= hold_reg & {WORD_W{write_out}};
        end
    end

    assign held_word_out = hold_reg;
    assign calling_p = party_of(hold_reg, CALLING_HI_A, CALLING_HI_B, CALLING_LO_LSB);
    assign called_p = party_of(hold_reg, CALLED_HI_A, CALLED_HI_B, CALLED_LO_LSB);
    assign called_zero = party_zero(called_p);
    assign calling_zero = party_zero(calling_p);

    tsd_onehot_dec #(.W_IN(GRP_W), .N_OUT(GRP_CNT)) u_calling_grp (
        .code_in(calling_p.grp),
        .en_in(1'b1),
        .onehot_out(calling_oh)
    );
    tsd_onehot_dec #(.W_IN(GRP_W), .N_OUT(GRP_CNT)) u_called_grp (
        .code_in(called_p.grp),
        .en_in(1'b1),
        .onehot_out(called_oh)
    );
    tsd_onehot_dec #(.W_IN(LINE_W), .N_OUT(DT_CNT)) u_dt (
        .code_in(called_p.line),
        .en_in(called_p.grp == SPECIAL_GRP && called_p.line < DT_LIMIT),
        .onehot_out(dt_oh)
    );
    tsd_onehot_dec #(.W_IN(LINE_W), .N_OUT(ATT_CNT)) u_att (
        .code_in(called_p.line - ATT_BASE),
        .en_in(called_p.grp == SPECIAL_GRP && called_p.line >= ATT_BASE && called_p.line < ATT_BASE + ATT_LIMIT),
        .onehot_out(att_oh)
    );

    assign dt_any = |dt_oh;
    assign cd0 = talk_slot_in && !called_zero && !hold_reg[CALLED_BUS_BIT];
    assign cd1 = talk_slot_in && !called_zero && hold_reg[CALLED_BUS_BIT];
    assign cg0 = talk_slot_in && !calling_zero && !hold_reg[CALLING_BUS_BIT];
    assign cg1 = talk_slot_in && !calling_zero && hold_reg[CALLING_BUS_BIT];

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            dec_valid_reg <= 1'b0;
            tdc_sel_reg <= 1'b0;
        end else if (ce_in) begin
            dec_valid_reg <= (phase_reg == ST_HOLD) && !slot_clr;
            tdc_sel_reg <= (phase_reg == ST_HOLD) && !slot_clr && time_division_controller_sel_in;
        end
    end
    // Pretranslator and intergroup outputs, held through the slot
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            calling_grp_out <= '0;
            called_grp_out <= '0;
            digit_trunk_sel_out <= '0;
            attendant_sel_out <= '0;
            called_addr_zero_out <= 1'b0;
            calling_addr_zero_out <= 1'b0;
            calling_zero_alt_out <= 1'b0;
            called_bus_bit_low_out <= 1'b0;
            called_bus0_drive_out <= 1'b0;
            called_bus1_drive_out <= 1'b0;
            calling_bus0_drive_out <= 1'b0;
            calling_bus1_drive_out <= 1'b0;
            digit_trunk_grp0_inhibit_out <= 1'b0;
            igs_bus0_out <= '0;
            igs_bus1_out <= '0;
            calling_select_leads_out <= '0;
            called_select_leads_out <= '0;
        end else if (ce_in) begin
            if (slot_clr || phase_reg != ST_HOLD) begin
                calling_grp_out <= '0;
                called_grp_out <= '0;
                digit_trunk_sel_out <= '0;
                attendant_sel_out <= '0;
                called_addr_zero_out <= 1'b0;
                calling_addr_zero_out <= 1'b0;
                calling_zero_alt_out <= 1'b0;
                called_bus_bit_low_out <= 1'b0;
                called_bus0_drive_out <= 1'b0;
                called_bus1_drive_out <= 1'b0;
                calling_bus0_drive_out <= 1'b0;
                calling_bus1_drive_out <= 1'b0;
                digit_trunk_grp0_inhibit_out <= 1'b0;
                igs_bus0_out <= '0;
                igs_bus1_out <= '0;
                calling_select_leads_out <= '0;
                called_select_leads_out <= '0;
            end else begin
                calling_grp_out <= calling_oh;
                called_grp_out <= called_oh;
                digit_trunk_sel_out <= dt_oh;
                attendant_sel_out <= att_oh;
                called_addr_zero_out <= talk_slot_in && called_zero;
                calling_addr_zero_out <= calling_zero;
                calling_zero_alt_out <= calling_zero;
                called_bus_bit_low_out <= !hold_reg[CALLED_BUS_BIT];
                called_bus0_drive_out <= cd0;
                called_bus1_drive_out <= cd1;
                calling_bus0_drive_out <= cg0;
                calling_bus1_drive_out <= cg1;
                digit_trunk_grp0_inhibit_out <= dt_any;
                for (int g = 0; g < GRP_CNT; g++) begin
                    igs_bus0_out[g] <= ((called_oh[g] && cd0) || (calling_oh[g] && cg0))
                                       && !(GRP_W'(g) == INHIBIT_GRP && dt_any);
                    igs_bus1_out[g] <= ((called_oh[g] && cd1) || (calling_oh[g] && cg1))
                                       && !(GRP_W'(g) == INHIBIT_GRP && dt_any)
                                       && !(GRP_W'(g) == TONE_GRP && tone_inh);
                end
                calling_select_leads_out <= time_division_controller_sel_in ? calling_p.line : '0;
                called_select_leads_out <= time_division_controller_sel_in ? called_p.line : '0;
            end
        end
    end

    // Two independent matrices per group, one for each party
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        tsd_matrix_xlat u_fwd (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .clr_in(slot_clr),
            .grp_en_in(calling_grp_out[g] && tdc_sel_reg),
            .res_strobe_in(res_strobe),
            .leads_in(calling_select_leads_out),
            .sel_out(fwd_matrix_sel_out[g])
        );
        tsd_matrix_xlat u_rev (
            .core_clk_in(core_clk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .clr_in(slot_clr),
            .grp_en_in(called_grp_out[g] && tdc_sel_reg),
            .res_strobe_in(res_strobe),
            .leads_in(called_select_leads_out),
            .sel_out(rev_matrix_sel_out[g])
        );
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in || !ce_in);
    sequence s_capture;
        phase_reg == ST_STROBE && phase_pulse_four_in;
    endsequence
    sequence s_slot_end;
        phase_reg == ST_HOLD ##1 phase_reg == ST_READ;
    endsequence
    a_word_capture: assert property (s_capture ##0 !shifted_msg_writeback_in
                                     |=> hold_reg == $past(sense_sync_reg))
        else $error("held word differs from sensed word");
    a_shift_write: assert property (s_capture ##0 shifted_msg_writeback_in
                                    |=> hold_reg[0] == $past(msg_shift_bit_in))
        else $error("shifted write-back lost message bit");
    a_digit_gate: assert property ((|digit_drive_out)
                                   |-> $past(write_out) && ((digit_drive_out & ~$past(hold_reg)) == '0))
        else $error("digit driver fired without write or bit");
    a_write_interval: assert property (s_capture |=> write_out && !strobe_out)
        else $error("write interval did not follow strobe");
    a_called_zero: assert property (phase_reg == ST_HOLD && !slot_clr && talk_slot_in && called_zero
                                    |=> called_addr_zero_out)
        else $error("called zero flag missing");
    a_calling_zero: assert property (calling_addr_zero_out |-> $past(calling_zero) && calling_zero_alt_out)
        else $error("calling zero flag without zero address");
    a_group_onehot: assert property (dec_valid_reg |-> $onehot(called_grp_out) && $onehot(calling_grp_out))
        else $error("group decode not one-hot");
    a_bus0_drive: assert property (called_bus0_drive_out
                                   |-> $past(!hold_reg[CALLED_BUS_BIT]) && called_bus_bit_low_out)
        else $error("bus-0 drive with bus bit set");
    a_grp0_block: assert property (digit_trunk_grp0_inhibit_out |-> !igs_bus0_out[0] && !igs_bus1_out[0])
        else $error("group-0 switch closed with digit trunk");
    a_tone_block: assert property (tone_inh |=> !igs_bus1_out[3])
        else $error("group-3 bus-1 switch closed under tone inhibit");
    a_slot_clear: assert property (s_slot_end |-> called_grp_out == '0 && calling_grp_out == '0 ##1
                                   rev_matrix_sel_out[0] == '0)
        else $error("selects not cleared at slot end");
endmodule : tsd_word_decode

// ==== testbench/tsd_circuit_model.sv ====
`timescale 1ns/1ps
module tsd_circuit_model (
    // Selects of one matrix
    input wire tsd_pkg::tsd_sel_s [tsd_pkg::NUM_GROUPS-1:0] sel_in,
    // Circuit that closes
    output logic [3:0] hits_out,
    output logic [3:0] grp_out,
    output logic [5:0] line_out,
    output logic stray_out
);
    import tsd_pkg::*;
    function automatic logic [1:0] enc(input logic [3:0] s);
        enc = {s[3] | s[2], s[3] | s[1]};
    endfunction : enc
    function automatic logic [5:0] line_of(input tsd_sel_s s);
        logic [1:0] c;
        c = enc(s.clk_sel);
        line_of = {c[1], enc(s.vert_sel), c[0], enc(s.horiz_sel)};
    endfunction : line_of
    // Counting hits catches two groups answering one address
    always_comb begin
        hits_out = 4'h0;
        grp_out = 4'h0;
        line_out = 6'h00;
        stray_out = 1'b0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if ($onehot(sel_in[g].clk_sel) && $onehot(sel_in[g].vert_sel)
                && $onehot(sel_in[g].horiz_sel)) begin
                hits_out = hits_out + 4'h1;
                grp_out = 4'(g);
                line_out = line_of(sel_in[g]);
            end else if (sel_in[g] != '0) begin
                stray_out = 1'b1;
            end
        end
    end
endmodule : tsd_circuit_model

// ==== testbench/tsd_word_decode_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tsd_word_decode_tb_top;
    import tsd_pkg::*;
    int n_tests = 0;
    int failures = 0;
    logic core_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, talk_slot_in = 1'b0, msg_shift_bit_in = 1'b0;
    logic phase_pulse_one_in = 1'b0, phase_pulse_two_in = 1'b0;
    logic phase_pulse_four_in = 1'b0, phase_pulse_seven_in = 1'b0;
    logic normal_msg_writeback_in = 1'b1, shifted_msg_writeback_in = 1'b0, time_division_controller_sel_in = 1'b0;
    logic tone_inhibit_a_in = 1'b0, tone_inhibit_b_in = 1'b0, resonant_strobe_in = 1'b0;
    logic [31:0] sense_bit_outputs_in = 32'h0, digit_drive_out, held_word_out;
    logic gate_out, read_out, strobe_out, write_out, called_addr_zero_out, calling_addr_zero_out, calling_zero_alt_out;
    logic called_bus_bit_low_out, called_bus0_drive_out, called_bus1_drive_out, calling_bus0_drive_out;
    logic calling_bus1_drive_out, digit_trunk_grp0_inhibit_out;
    logic [15:0] calling_grp_out, called_grp_out, igs_bus0_out, igs_bus1_out;
    logic [5:0] digit_trunk_sel_out, calling_select_leads_out, called_select_leads_out, fl, rl;
    logic [11:0] attendant_sel_out;
    tsd_sel_s [NUM_GROUPS-1:0] fwd_matrix_sel_out, rev_matrix_sel_out;
    logic [3:0] fh, fg, rh, rg;
    logic fs, rs;
    wire [4:0] drv_seen = {calling_bus0_drive_out, calling_bus1_drive_out, called_bus0_drive_out,
                           called_bus1_drive_out, called_bus_bit_low_out};
    wire [2:0] zero_seen = {calling_addr_zero_out, calling_zero_alt_out, called_addr_zero_out};

    tsd_word_decode tsd_word_decode_inst (.*);
    tsd_circuit_model fwd_model_inst (.sel_in(fwd_matrix_sel_out), .hits_out(fh), .grp_out(fg),
                                      .line_out(fl), .stray_out(fs));
    tsd_circuit_model rev_model_inst (.sel_in(rev_matrix_sel_out), .hits_out(rh), .grp_out(rg),
                                      .line_out(rl), .stray_out(rs));

    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #5;
    endtask : step

    task automatic pulse(ref logic p);
        p = 1'b1;
        step(1);
        p = 1'b0;
        step(2);
    endtask : pulse

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // One talking slot: drive the word, walk the phases, check every decode but the intergroup switches other than group-0 bus 0 and group-3 bus 1
    task automatic slot(input string nm, input logic [3:0] cg, input logic [5:0] cl, input logic [3:0] bg,
                        input logic [5:0] bl, input logic talk, input logic time_division_controller, input logic res, input logic sh);
        logic [31:0] w;
        logic [31:0] hw;
        logic az;
        logic bz;
        logic inh;
        logic [3:0] dv;
        logic tin;
        w = 32'h0000FC3F;
        {w[7], w[9], w[31:24]} = {cg, cl};
        {w[6], w[8], w[23:16]} = {bg, bl};
        hw = sh ? {w[30:0], msg_shift_bit_in} : w;
        {cg, cl} = {hw[7], hw[9], hw[31:24]};
        {bg, bl} = {hw[6], hw[8], hw[23:16]};
        az = {cg, cl} == 10'h000;
        bz = {bg, bl} == 10'h000;
        inh = bg == 4'hF && bl < 6'h06;
        tin = tone_inhibit_a_in | tone_inhibit_b_in;
        dv = {talk & !az & !hw[26], talk & !az & hw[26], talk & !bz & !hw[18], talk & !bz & hw[18]};
        sense_bit_outputs_in = w;
        talk_slot_in = talk;
        time_division_controller_sel_in = time_division_controller;
        resonant_strobe_in = res;
        shifted_msg_writeback_in = sh;
        normal_msg_writeback_in = !sh;
        step(4);
        pulse(phase_pulse_one_in);
        `CHK("gate read", 2'b11, {gate_out, read_out})
        `CHK("cleared", 24'h0, {calling_grp_out, fh, rh})
        pulse(phase_pulse_two_in);
        `CHK("read strobe", 2'b01, {read_out, strobe_out})
        pulse(phase_pulse_four_in);
        step(1);
        `CHK("strobe write", 2'b01, {strobe_out, write_out})
        `CHK("held", hw, held_word_out)
        `CHK("drive on", hw, digit_drive_out)
        pulse(phase_pulse_seven_in);
        `CHK("write gate", 2'b00, {write_out, gate_out})
        `CHK("drive off", 32'h0, digit_drive_out)
        `CHK("calling grp", 16'h1 << cg, calling_grp_out)
        `CHK("called grp", 16'h1 << bg, called_grp_out)
        `CHK("zeros", {az, az, talk & bz}, zero_seen)
        `CHK("leads", time_division_controller ? {cl, bl} : 12'h0, {calling_select_leads_out, called_select_leads_out})
        `CHK("drives", {dv, !hw[18]}, drv_seen)
        `CHK("trunk", inh ? 6'h01 << bl : 6'h00, digit_trunk_sel_out)
        `CHK("att", 12'(bg == 4'hF && bl >= 6'h10 && bl < 6'h1C) << (bl - 6'h10), attendant_sel_out)
        `CHK("trunk inh", inh, digit_trunk_grp0_inhibit_out)
        `CHK("g0b0", (cg == 4'h0 && dv[3] || bg == 4'h0 && dv[1]) && !inh, igs_bus0_out[0])
        `CHK("grp3_bus1_switch", (cg == 4'h3 && dv[2] || bg == 4'h3 && dv[0]) && !tin, igs_bus1_out[3])
        `CHK("fwd", (time_division_controller && res && cg < 4'hF) ? {4'h1, cg, cl} : 14'h0, {fh, fg, fl})
        `CHK("rev", (time_division_controller && res && bg < 4'hF) ? {4'h1, bg, bl} : 14'h0, {rh, rg, rl})
        `CHK("stray", {2{time_division_controller && !res}} & {cg < 4'hF, bg < 4'hF}, {fs, rs})
        $display("test %s done", nm);
    endtask : slot

    initial begin
        step(16);
        rst_in = 1'b0;
        step(1);
        slot("basic", 4'h5, 6'h2D, 4'h9, 6'h13, 1'b1, 1'b1, 1'b1, 1'b0);
        slot("no strobe", 4'h5, 6'h2D, 4'h9, 6'h13, 1'b1, 1'b1, 1'b0, 1'b0);
        slot("no ctrl", 4'h5, 6'h2D, 4'h9, 6'h13, 1'b1, 1'b0, 1'b1, 1'b0);
        slot("same grp", 4'h7, 6'h15, 4'h7, 6'h2A, 1'b1, 1'b1, 1'b1, 1'b0);
        slot("edge grp", 4'hE, 6'h3F, 4'h0, 6'h01, 1'b1, 1'b1, 1'b1, 1'b0);
        slot("zero talk", 4'h0, 6'h00, 4'h0, 6'h00, 1'b1, 1'b0, 1'b1, 1'b0);
        slot("zero idle", 4'h0, 6'h00, 4'h0, 6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        slot("shifted", 4'h5, 6'h2D, 4'h9, 6'h13, 1'b1, 1'b1, 1'b1, 1'b1);
        for (int k = 0; k < 6; k++) begin
            slot("trunk", 4'h0, 6'h01, 4'hF, 6'(k), 1'b1, 1'b1, 1'b1, 1'b0);
        end
        for (int k = 0; k < 12; k++) begin
            slot("attendant", 4'h2, 6'h07, 4'hF, 6'(16 + k), 1'b1, 1'b1, 1'b1, 1'b0);
        end
        for (int k = 0; k < 3; k++) begin
            tone_inhibit_a_in = k == 1;
            tone_inhibit_b_in = k == 2;
            slot("tone", 4'h3, 6'h04, 4'h6, 6'h09, 1'b1, 1'b1, 1'b1, 1'b0);
        end
        report_and_stop();
    end

    // About twelve times the expected run
    initial begin
        repeat (6000) @(posedge core_clk_in);
        failures++;
        report_and_stop();
    end
endmodule : tsd_word_decode_tb_top
